// *** rtl/cie_pkg.sv ***
// Constants, register layout and carrier types of the CAN interrupt
// enable and request gating block.
// Assumes a 32-bit AXI4-Lite register bus and status inputs on aclk.
//
// What this block does
// - Sleep-entry request: enable bit 17 and flag.
// - Sleep-exit request: enable bit 16 and flag.
// - Error request: enable bit 15 and error flag.
// - Error-type update sets error flag if bit 11.
// - Bus-off entry sets error flag if bit 10.
// - Error-passive entry sets error flag if bit 9.
// - Error-warning entry sets error flag if bit 8.
// - FIFO 1 overflow request: bit 6 and flag.
// - FIFO 1 full request: bit 5 and flag.
// - FIFO 1 pending request: bit 4, count nonzero.
// - FIFO 0 overflow request: bit 3 and flag.
// - FIFO 0 full request: bit 2 and flag.
// - FIFO 0 pending request: bit 1, count nonzero.
// - Transmit request: bit 0 and any done flag.
// - Bus-off when transmit error count exceeds 255.
// - Error-passive when either counter exceeds 127.
// - Pending count nonzero while messages wait.
package cie_pkg;

    // ========================================================
    // Register map and field positions
    localparam logic [7:0] OFF_ENABLE = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_REQ    = 8'h08;
    localparam logic [7:0] OFF_ETY    = 8'h0C;
    localparam logic [31:0] EN_MASK   = 32'h0003_8F7F;
    localparam logic [31:0] EN_RESET  = 32'h0000_0000;
    localparam int unsigned EN_TX = 0;
    localparam int unsigned EN_F0_PEND = 1;
    localparam int unsigned EN_F0_FULL = 2;
    localparam int unsigned EN_F0_OVF = 3;
    localparam int unsigned EN_F1_PEND = 4;
    localparam int unsigned EN_F1_FULL = 5;
    localparam int unsigned EN_F1_OVF = 6;
    localparam int unsigned EN_WARN = 8;
    localparam int unsigned EN_ETY = 11;
    localparam int unsigned EN_ERR = 15;
    localparam int unsigned EN_SLEEP_EXIT = 16;
    localparam int unsigned EN_SLEEP_ENTRY = 17;
    localparam int unsigned ST_EOF_BIT = 17;
    localparam logic [2:0] ETY_RESET = 3'h0;

    // ========================================================
    // Error state limits
    localparam logic [8:0] BUSOFF_LIMIT  = 9'h0FF;
    localparam logic [7:0] PASSIVE_LIMIT = 8'h7F;
    localparam logic [7:0] WARN_LIMIT    = 8'h60;

    // ========================================================
    // Bus answers
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ========================================================
    // Carriers
    typedef struct packed {
        logic [2:0] tx_done;
        logic       sleep_entry;
        logic       sleep_exit;
        logic       fifo1_ovf;
        logic       fifo1_full;
        logic [1:0] fifo1_cnt;
        logic       fifo0_ovf;
        logic       fifo0_full;
        logic [1:0] fifo0_cnt;
    } cie_flags_type;

    typedef struct packed {
        logic bus_off;
        logic passive;
        logic warning;
    } cie_err_type;

    typedef struct packed {
        logic sleep_entry;
        logic sleep_exit;
        logic error;
        logic f1_ovf;
        logic f1_full;
        logic f1_pend;
        logic f0_ovf;
        logic f0_full;
        logic f0_pend;
        logic tx;
    } cie_irq_type;

endpackage

// *** rtl/cie_err_src.sv ***
// Error state levels derived from the error counters, and a one-cycle
// pulse when each state is entered.
// Assumes both counters are driven by logic on aclk.
`timescale 1ns/1ps
module cie_err_src (
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    input  wire logic [8:0]           tx_error_counter,
    input  wire logic [7:0]           rx_error_counter,
    output cie_pkg::cie_err_type      level,
    output cie_pkg::cie_err_type      entered
);
    cie_pkg::cie_err_type level_ff;
    cie_pkg::cie_err_type nxt_level;

    // ========================================================
    // Threshold compare; the counter carries a ninth bit so that
    // a count past 255 can be seen at all.
    assign nxt_level.bus_off = tx_error_counter > cie_pkg::BUSOFF_LIMIT;
    assign nxt_level.passive = (tx_error_counter > 9'(cie_pkg::PASSIVE_LIMIT))
                             | (rx_error_counter > cie_pkg::PASSIVE_LIMIT);
    assign nxt_level.warning = (tx_error_counter >= 9'(cie_pkg::WARN_LIMIT))
                             | (rx_error_counter >= cie_pkg::WARN_LIMIT);

    // Entry is the cycle the compare first goes true.
    assign entered = nxt_level & ~level_ff;
    assign level   = level_ff;

    // Level register, cleared by reset.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            level_ff <= '0;
        end else begin
            level_ff <= nxt_level;
        end
    end
endmodule // cie_err_src

// *** rtl/cie_eo_flag.sv ***
// Sticky aggregated error-occurred flag with gated set sources.
// Assumes set sources are one-cycle pulses on aclk.
`timescale 1ns/1ps
module cie_eo_flag (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic [3:0] src,
    input  wire logic [3:0] en,
    input  wire logic       clr,
    output logic            flag
);
    logic flag_ff;
    logic set_any;
    logic nxt_flag;

    // ========================================================
    // Sources are {type update, bus-off, passive, warning}; each
    // only counts while its enable is set.
    assign set_any  = |(src & en);
    // A set arriving with a clear wins, so no event is lost.
    assign nxt_flag = set_any | (flag_ff & ~clr);
    assign flag     = flag_ff;

    // Flag register.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flag_ff <= 1'b0;
        end else begin
            flag_ff <= nxt_flag;
        end
    end
endmodule // cie_eo_flag

// *** rtl/cie_top.sv ***
// Top of the CAN interrupt enable and request gating block: AXI4-Lite
// register slave, enable register, error-type record and gating.
// Assumes all status inputs come from CAN logic clocked by aclk, and
// that one write and one read are under way at a time at most.
//
// Implementation choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
module cie_top (
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    // AXI4-Lite write address.
    input  wire logic [7:0]            s_axi_awaddr,
    input  wire logic [2:0]            s_axi_awprot,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    // AXI4-Lite write data.
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    // AXI4-Lite write response.
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    // AXI4-Lite read address.
    input  wire logic [7:0]            s_axi_araddr,
    input  wire logic [2:0]            s_axi_arprot,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    // AXI4-Lite read data.
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    // Status from the CAN engine.
    input  cie_pkg::cie_flags_type     can_flags,
    input  wire logic [8:0]            tx_error_counter,
    input  wire logic [7:0]            rx_error_counter,
    input  wire logic                  error_type_wr,
    input  wire logic [2:0]            error_type_field,
    // Requests toward the interrupt controller.
    output cie_pkg::cie_irq_type       irq_req,
    output logic [2:0]                 error_type_record
);

    // ========================================================
    // Declarations
    logic                 aw_held_ff;
    logic [7:0]           awaddr_ff;
    logic                 w_held_ff;
    logic [31:0]          wdata_ff;
    logic [3:0]           wstrb_ff;
    logic                 bvalid_ff;
    logic [1:0]           bresp_ff;
    logic                 rvalid_ff;
    logic [31:0]          rdata_ff;
    logic [1:0]           rresp_ff;
    logic [31:0]          enable_ff;
    logic [31:0]          nxt_enable;
    logic [2:0]           ety_ff;
    logic [2:0]           nxt_ety;
    logic                 aw_take;
    logic                 w_take;
    logic                 ar_take;
    logic                 do_wr;
    logic                 hit_en_w;
    logic                 hit_st_w;
    logic                 hit_req_w;
    logic                 hit_ety_w;
    logic                 wr_ok;
    logic                 hit_en_r;
    logic                 hit_st_r;
    logic                 hit_req_r;
    logic                 hit_ety_r;
    logic                 rd_ok;
    logic [31:0]          wr_bits;
    logic [31:0]          rd_word;
    logic [31:0]          status_word;
    logic [31:0]          req_word;
    logic                 eo_clr;
    logic                 eo_flag;
    logic [3:0]           eo_src;
    logic [3:0]           eo_en;
    logic                 sw_ety_wr;
    logic                 f0_pend;
    logic                 f1_pend;
    logic                 tx_any;
    cie_pkg::cie_err_type err_level;
    cie_pkg::cie_err_type err_entered;
    cie_pkg::cie_irq_type irq_now;

    // ========================================================
    // Write channel handshakes
    // Address and data are each held in a one-entry slot, so the
    // master may offer them in either order. A slot refuses new
    // items until the response has been taken.
    assign s_axi_awready = !aw_held_ff && !bvalid_ff;
    assign s_axi_wready  = !w_held_ff && !bvalid_ff;
    assign aw_take       = s_axi_awvalid && s_axi_awready;
    assign w_take        = s_axi_wvalid && s_axi_wready;
    // The register write happens once both slots are full.
    assign do_wr         = aw_held_ff && w_held_ff && !bvalid_ff;

    // Address slot.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_ff <= 1'b0;
            awaddr_ff  <= '0;
        end else if (aw_take) begin
            aw_held_ff <= 1'b1;
            awaddr_ff  <= s_axi_awaddr;
        end else if (do_wr) begin
            aw_held_ff <= 1'b0;
        end
    end

    // Data slot with its byte strobes.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_ff <= 1'b0;
            wdata_ff  <= '0;
            wstrb_ff  <= '0;
        end else if (w_take) begin
            w_held_ff <= 1'b1;
            wdata_ff  <= s_axi_wdata;
            wstrb_ff  <= s_axi_wstrb;
        end else if (do_wr) begin
            w_held_ff <= 1'b0;
        end
    end

    // ========================================================
    // Write decode
    // Protection bits are accepted but not checked; the block has
    // no secure or privileged registers.
    assign hit_en_w  = awaddr_ff == cie_pkg::OFF_ENABLE;
    assign hit_st_w  = awaddr_ff == cie_pkg::OFF_STATUS;
    assign hit_req_w = awaddr_ff == cie_pkg::OFF_REQ;
    assign hit_ety_w = awaddr_ff == cie_pkg::OFF_ETY;
    assign wr_ok     = hit_en_w | hit_st_w | hit_req_w | hit_ety_w;

    // Byte strobes expand to a bit mask, one generate entry a lane.
    for (genvar lane = 0; lane < 4; lane++) begin : g_lane
        assign wr_bits[lane*8 +: 8] = {8{wstrb_ff[lane]}};
    end

    // Write response: OKAY for mapped words, SLVERR otherwise. The
    // request word is read-only, so writes to it are ignored.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_ff <= 1'b0;
            bresp_ff  <= cie_pkg::RESP_OKAY;
        end else if (do_wr) begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= wr_ok ? cie_pkg::RESP_OKAY : cie_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp  = bresp_ff;

    // ========================================================
    // Enable register
    // Reserved positions never store a one, so they read back as zero
    // even if software breaks the write convention.
    assign nxt_enable = (enable_ff & ~wr_bits)
                      | (wdata_ff & wr_bits & cie_pkg::EN_MASK);

    // Enables start cleared: nothing requests until software opens it.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            enable_ff <= cie_pkg::EN_RESET;
        end else if (do_wr && hit_en_w) begin
            enable_ff <= nxt_enable;
        end
    end

    // ========================================================
    // Error-type record
    // Hardware wins over a same-cycle software write; software may
    // load code seven to watch for the next hardware update.
    assign sw_ety_wr = do_wr && hit_ety_w && wstrb_ff[0];
    assign nxt_ety   = error_type_wr ? error_type_field
                     : sw_ety_wr ? wdata_ff[2:0] : ety_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ety_ff <= cie_pkg::ETY_RESET;
        end else begin
            ety_ff <= nxt_ety;
        end
    end

    assign error_type_record = ety_ff;

    // ========================================================
    // Error state levels and entry pulses
    cie_err_src u_err_src (
        .aclk             (aclk),
        .aresetn          (aresetn),
        .tx_error_counter (tx_error_counter),
        .rx_error_counter (rx_error_counter),
        .level            (err_level),
        .entered          (err_entered)
    );

    // ========================================================
    // Aggregated error-occurred flag
    // Software clears it by writing one to its status position.
    assign eo_clr = do_wr && hit_st_w && wr_bits[cie_pkg::ST_EOF_BIT]
                  && wdata_ff[cie_pkg::ST_EOF_BIT];
    assign eo_src = {error_type_wr, err_entered.bus_off,
                     err_entered.passive, err_entered.warning};
    assign eo_en  = {enable_ff[cie_pkg::EN_ETY],
                     enable_ff[cie_pkg::EN_ETY - 1],
                     enable_ff[cie_pkg::EN_WARN + 1],
                     enable_ff[cie_pkg::EN_WARN]};

    cie_eo_flag u_eo_flag (
        .aclk    (aclk),
        .aresetn (aresetn),
        .src     (eo_src),
        .en      (eo_en),
        .clr     (eo_clr),
        .flag    (eo_flag)
    );

    // ========================================================
    // Request gating
    // Each request is a pure AND of its enable and its flag, so it
    // drops in the same cycle either input falls.
    assign f0_pend = |can_flags.fifo0_cnt;
    assign f1_pend = |can_flags.fifo1_cnt;
    assign tx_any  = |can_flags.tx_done;

    assign irq_now.sleep_entry = enable_ff[cie_pkg::EN_SLEEP_ENTRY]
                               & can_flags.sleep_entry;
    assign irq_now.sleep_exit  = enable_ff[cie_pkg::EN_SLEEP_EXIT]
                               & can_flags.sleep_exit;
    assign irq_now.error       = enable_ff[cie_pkg::EN_ERR] & eo_flag;
    assign irq_now.f1_ovf      = enable_ff[cie_pkg::EN_F1_OVF]
                               & can_flags.fifo1_ovf;
    assign irq_now.f1_full     = enable_ff[cie_pkg::EN_F1_FULL]
                               & can_flags.fifo1_full;
    assign irq_now.f1_pend     = enable_ff[cie_pkg::EN_F1_PEND] & f1_pend;
    assign irq_now.f0_ovf      = enable_ff[cie_pkg::EN_F0_OVF]
                               & can_flags.fifo0_ovf;
    assign irq_now.f0_full     = enable_ff[cie_pkg::EN_F0_FULL]
                               & can_flags.fifo0_full;
    assign irq_now.f0_pend     = enable_ff[cie_pkg::EN_F0_PEND] & f0_pend;
    assign irq_now.tx          = enable_ff[cie_pkg::EN_TX] & tx_any;

    assign irq_req = irq_now;

    // ========================================================
    // Read words
    // Status: flags in bits 12:0, bit 13 spare, error levels above
    // them and the sticky error flag on top; requests mirror irq_req.
    assign status_word = {14'h0000, eo_flag, err_level, 1'b0, can_flags};
    assign req_word    = {22'h00_0000, irq_now};

    assign hit_en_r  = s_axi_araddr == cie_pkg::OFF_ENABLE;
    assign hit_st_r  = s_axi_araddr == cie_pkg::OFF_STATUS;
    assign hit_req_r = s_axi_araddr == cie_pkg::OFF_REQ;
    assign hit_ety_r = s_axi_araddr == cie_pkg::OFF_ETY;
    assign rd_ok     = hit_en_r | hit_st_r | hit_req_r | hit_ety_r;

    assign rd_word = hit_en_r  ? enable_ff
                   : hit_st_r  ? status_word
                   : hit_req_r ? req_word
                   : hit_ety_r ? {29'h0000_0000, ety_ff}
                   : 32'h0000_0000;

    // ========================================================
    // Read channel
    // No address is taken while data waits: one read in flight, and
    // the data stay stable until taken.
    assign s_axi_arready = !rvalid_ff;
    assign ar_take       = s_axi_arvalid && s_axi_arready;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= '0;
            rresp_ff  <= cie_pkg::RESP_OKAY;
        end else if (ar_take) begin
            rvalid_ff <= 1'b1;
            rdata_ff  <= rd_word;
            rresp_ff  <= rd_ok ? cie_pkg::RESP_OKAY : cie_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata  = rdata_ff;
    assign s_axi_rresp  = rresp_ff;

endmodule // cie_top

// *** dv/cie_top_chk.sv ***
// Concurrent checks on the ports of the interrupt gating block.
// Assumes it is bound onto cie_top, one clock aclk, synchronous reset.
`timescale 1ns/1ps
module cie_top_chk (
    input wire logic              aclk,
    input wire logic              aresetn,
    input cie_pkg::cie_flags_type can_flags,
    input cie_pkg::cie_irq_type   irq_req,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_rready,
    input wire logic [31:0]       s_axi_rdata
);
    // ============================================================
    // Request gating: a request never stands without its own flag.
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sleep_entry_a: assert property (irq_req.sleep_entry |-> can_flags.sleep_entry)
        else $error("sleep entry request without flag");
    sleep_exit_a: assert property (irq_req.sleep_exit |-> can_flags.sleep_exit)
        else $error("sleep exit request without flag");
    f1_ovf_a: assert property (irq_req.f1_ovf |-> can_flags.fifo1_ovf)
        else $error("fifo1 overflow request without flag");
    f1_full_a: assert property (irq_req.f1_full |-> can_flags.fifo1_full)
        else $error("fifo1 full request without flag");
    f1_pend_a: assert property (irq_req.f1_pend |-> can_flags.fifo1_cnt != 2'h0)
        else $error("fifo1 pending request with empty count");
    f0_ovf_a: assert property (irq_req.f0_ovf |-> can_flags.fifo0_ovf)
        else $error("fifo0 overflow request without flag");
    f0_full_a: assert property (irq_req.f0_full |-> can_flags.fifo0_full)
        else $error("fifo0 full request without flag");
    f0_pend_a: assert property (irq_req.f0_pend |-> can_flags.fifo0_cnt != 2'h0)
        else $error("fifo0 pending request with empty count");
    tx_done_a: assert property (irq_req.tx |-> |can_flags.tx_done)
        else $error("transmit request without done flag");
    // Enables restart at zero, so the first cycles after reset stay quiet.
    reset_quiet_a: assert property ($rose(aresetn) |-> (irq_req == '0) [*2])
        else $error("request raised right after reset");
    // Read data must not move while the master is still stalling.
    read_hold_a: assert property (s_axi_rvalid && !s_axi_rready
            |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped or changed before taken");

    cover property (irq_req.error);
    cover property (irq_req.tx && irq_req.f0_pend && irq_req.f1_pend);
    cover property (s_axi_rvalid && !s_axi_rready);
endmodule // cie_top_chk

bind cie_top cie_top_chk u_chk (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .can_flags   (can_flags),
    .irq_req     (irq_req),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .s_axi_rdata (s_axi_rdata)
);

// *** dv/cie_intc_model.sv ***
// Interrupt controller stand-in: latches every request line seen high.
// Assumes level requests on aclk; the bench acknowledges serviced lines.
`timescale 1ns/1ps
module cie_intc_model (
    input wire logic            aclk,
    input wire logic            aresetn,
    input cie_pkg::cie_irq_type irq_req,
    input wire logic [9:0]      ack,
    output logic [9:0]          pending_ff
);
    // ============================================================
    // Sticky capture, so even a one-cycle glitch on a line is kept.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pending_ff <= 10'h000;
        end else begin
            pending_ff <= (pending_ff & ~ack) | irq_req;
        end
    end
endmodule // cie_intc_model

// *** dv/cie_top_test.sv ***
// Self-checking bench of the interrupt enable and gating block.
// Assumes cie_top with its bound checker and the controller model.
`timescale 1ns/1ps
module cie_top_test;
    // ============================================================
    // Clock, reset and stimulus.
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic ety_wr = 1'b0;
    logic [2:0] ety_val = 3'h0;
    logic [8:0] txc = 9'h000;
    logic [7:0] rxc = 8'h00;
    logic [9:0] ack = 10'h000;
    cie_pkg::cie_flags_type flags = '0;
    cie_pkg::cie_irq_type irq;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [9:0] pend;
    logic [2:0] ety_rec;
    logic [31:0] d;
    logic [1:0] r;
    int num_errors = 0;
    int n_checks = 0;

    always #4 aclk = ~aclk;

    cie_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .can_flags(flags), .tx_error_counter(txc), .rx_error_counter(rxc),
        .error_type_wr(ety_wr), .error_type_field(ety_val), .irq_req(irq),
        .error_type_record(ety_rec));
    cie_intc_model u_intc (.aclk(aclk), .aresetn(aresetn), .irq_req(irq), .ack(ack),
        .pending_ff(pend));

    // ============================================================
    // Compare and bus tasks; bus outputs sampled at negedge.
    task automatic chk(input string what, input logic [31:0] exp, got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        bit aw_h, w_h, done;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge aclk);
            aw_h = awready;
            w_h = wready;
            done = bvalid;
            r = bresp;
            @(posedge aclk);
            if (aw_h) awvalid <= 1'b0;
            if (w_h) wvalid <= 1'b0;
            if (done) bready <= 1'b0;
        end while (!done);
    endtask

    // Ready is raised one cycle late so that the stall path is exercised.
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        bit ar_h, rv, done;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(negedge aclk);
            ar_h = arready;
            rv = rvalid;
            done = rvalid && rready;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ar_h) arvalid <= 1'b0;
            rready <= rv && !done;
        end while (!done);
    endtask

    task automatic drive(input logic [12:0] f);
        @(posedge aclk);
        flags <= f;
        @(negedge aclk);
    endtask

    // Counter and error-type stimulus, then back to a quiet state.
    task automatic fire(input logic w, input logic [8:0] t_v, input logic [7:0] r_v);
        @(posedge aclk);
        ack <= 10'h3FF;
        @(posedge aclk);
        ack <= 10'h000;
        ety_val <= 3'h5;
        ety_wr <= w;
        txc <= t_v;
        rxc <= r_v;
        @(posedge aclk);
        ety_wr <= 1'b0;
        repeat (6) @(posedge aclk);
        txc <= 9'h000;
        rxc <= 8'h00;
        repeat (4) @(negedge aclk);
    endtask

    // ============================================================
    // Scenarios.
    task automatic t_reset();
        drive(13'h1FFF);
        chk("irq with enables at reset", 32'h0, {22'h0, irq});
        rd(cie_pkg::OFF_ENABLE, d, r);
        chk("enable reset value", cie_pkg::EN_RESET, d);
    endtask

    task automatic t_regs();
        wr(cie_pkg::OFF_ENABLE, 32'h0003_8F7F, r);
        rd(cie_pkg::OFF_ENABLE, d, r);
        chk("enable readback", 32'h0003_8F7F, d);
        rd(8'h40, d, r);
        chk("unmapped read response", {30'h0, cie_pkg::RESP_SLVERR}, {30'h0, r});
        wr(cie_pkg::OFF_ENABLE, 32'h0000_0000, r);
        chk("irq after disable", 32'h0, {22'h0, irq});
    endtask

    task automatic t_gating();
        int en_bit[9] = '{17, 16, 6, 5, 4, 3, 2, 1, 0};
        int irq_bit[9] = '{9, 8, 6, 5, 4, 3, 2, 1, 0};
        for (int k = 0; k < 9; k++) begin
            drive(13'h0000);
            wr(cie_pkg::OFF_ENABLE, 32'h1 << en_bit[k], r);
            drive(13'h1FFF);
            chk("gated request", 32'h1 << irq_bit[k], {22'h0, irq});
            drive(13'h0000);
            chk("request after flag drop", 32'h0, {22'h0, irq});
        end
        wr(cie_pkg::OFF_ENABLE, 32'h0000_0013, r);
        drive(13'h0411);
        chk("count one and single done", 32'h13, {22'h0, irq});
        drive(13'h0000);
    endtask

    task automatic t_errors();
        int src[4] = '{11, 10, 9, 8};
        logic [8:0] tv[4] = '{9'h000, 9'h100, 9'h000, 9'h000};
        logic [7:0] rv[4] = '{8'h00, 8'h00, 8'h80, 8'h60};
        wr(cie_pkg::OFF_ENABLE, 32'h0000_8000, r);
        fire(1'b1, 9'h100, 8'h80);
        chk("error with sources masked", 32'h0, {31'h0, pend[7]});
        chk("error type record", 32'h5, {29'h0, ety_rec});
        wr(cie_pkg::OFF_ENABLE, 32'h0000_8400, r);
        fire(1'b0, 9'h0FF, 8'h7F);
        chk("error at counter limits", 32'h0, {31'h0, pend[7]});
        for (int k = 0; k < 4; k++) begin
            wr(cie_pkg::OFF_ENABLE, 32'h0000_8000 | (32'h1 << src[k]), r);
            fire(k == 0, tv[k], rv[k]);
            chk("error request", 32'h1, {31'h0, irq.error});
            wr(cie_pkg::OFF_STATUS, 32'h1 << cie_pkg::ST_EOF_BIT, r);
            @(negedge aclk);
            chk("error request after clear", 32'h0, {31'h0, irq.error});
        end
    endtask

    task automatic final_report();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ============================================================
    // Main sequence and a watchdog well above its expected length.
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_regs();
        t_gating();
        t_errors();
        final_report();
    end

    initial begin
        repeat (8000) @(posedge aclk);
        num_errors++;
        final_report();
    end
endmodule // cie_top_test
